//--- src/rosel_pkg.sv
// Constants and register map of the remappable output selector bank.
// Assumes a 32-bit classic Wishbone slave port with byte addressing.
package rosel_pkg;

  // Widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADR_W = 14;
  localparam int unsigned IDX_W = 12;
  localparam int unsigned SEL_W = 5;
  localparam int unsigned REG_W = 8;
  localparam int unsigned SELIDX_W = 4;
  localparam int unsigned BE_W = 4;
  localparam int unsigned NUM_SEL = 15;
  localparam int unsigned NUM_SEL_SMALL = 9;
  localparam int unsigned NUM_CODE = 32;
  localparam int unsigned PIN_FIRST = 10;
  localparam int unsigned IDX_LSB = 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_REMAP_OUT_SEL_PIN10 = 12'heca;
  localparam logic [IDX_W-1:0] IDX_REMAP_OUT_SEL_PIN11 = 12'hecb;
  localparam logic [IDX_W-1:0] IDX_REMAP_OUT_SEL_PIN12 = 12'hecc;
  localparam logic [IDX_W-1:0] IDX_REMAP_OUT_SEL_PIN13 = 12'hecd;
  localparam logic [IDX_W-1:0] IDX_REMAP_OUT_SEL_PIN14 = 12'hece;
  localparam logic [IDX_W-1:0] IDX_REMAP_OUT_SEL_PIN15 = 12'hecf;
  localparam logic [IDX_W-1:0] IDX_REMAP_OUT_SEL_PIN16 = 12'hed0;
  localparam logic [IDX_W-1:0] IDX_REMAP_OUT_SEL_PIN17 = 12'hed1;
  localparam logic [IDX_W-1:0] IDX_REMAP_OUT_SEL_PIN18 = 12'hed2;
  localparam logic [IDX_W-1:0] IDX_REMAP_OUT_SEL_PIN19 = 12'hed3;
  localparam logic [IDX_W-1:0] IDX_REMAP_OUT_SEL_PIN20 = 12'hed4;
  localparam logic [IDX_W-1:0] IDX_REMAP_OUT_SEL_PIN21 = 12'hed5;
  localparam logic [IDX_W-1:0] IDX_REMAP_OUT_SEL_PIN22 = 12'hed6;
  localparam logic [IDX_W-1:0] IDX_REMAP_OUT_SEL_PIN23 = 12'hed7;
  localparam logic [IDX_W-1:0] IDX_REMAP_OUT_SEL_PIN24 = 12'hed8;
  localparam logic [IDX_W-1:0] IDX_REMAP_LOCK = 12'hee0;

  // Fields and reset values
  localparam int unsigned LOCK_BIT = 0;
  localparam int unsigned LANE0 = 0;
  localparam logic [SEL_W-1:0] SEL_RST = 5'h00;
  localparam logic LOCK_RST = 1'b0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // Register index of a byte address
  function automatic logic [IDX_W-1:0] reg_index(input logic [ADR_W-1:0] adr);
    return adr[ADR_W-1:IDX_LSB];
  endfunction

endpackage

//--- src/rosel_addr_decode.sv
// Address decoder of the selector bank.
// Assumes a byte address from a Wishbone slave; purely combinational.
`timescale 1ns/1ps
module rosel_addr_decode
  import rosel_pkg::*;
(
  // Request
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic large_pkg_i,
  // Decode
  output logic sel_hit_o,
  output logic [SELIDX_W-1:0] sel_idx_o,
  output logic lock_hit_o
);

  logic [IDX_W-1:0] idx;
  logic [IDX_W-1:0] last;

  always_comb begin
    idx = reg_index(adr_i);
    // Upper selectors do not exist on the small package
    last = large_pkg_i ? IDX_REMAP_OUT_SEL_PIN24 : IDX_REMAP_OUT_SEL_PIN18; // RQ5
    sel_hit_o = (idx >= IDX_REMAP_OUT_SEL_PIN10) && (idx <= last);
    sel_idx_o = SELIDX_W'(idx - IDX_REMAP_OUT_SEL_PIN10);
    lock_hit_o = (idx == IDX_REMAP_LOCK);
  end

endmodule // rosel_addr_decode

//--- src/rosel_pin_mux.sv
// Output selector of one remappable pin.
// Assumes peripheral and port outputs are on the system clock.
`timescale 1ns/1ps
module rosel_pin_mux
  import rosel_pkg::*;
(
  // Selection
  input wire logic [SEL_W-1:0] code_i,
  input wire logic [NUM_CODE-1:0] defined_i,
  // Sources
  input wire logic [NUM_CODE-1:0] periph_i,
  input wire logic gpio_i,
  // Result
  output logic pin_o,
  output logic remap_o
);

  always_comb begin
    remap_o = defined_i[code_i]; // RQ6
    pin_o = remap_o ? periph_i[code_i] : gpio_i; // RQ1
  end

endmodule // rosel_pin_mux

//--- src/rosel_top.sv
// Remappable output selector bank for pins 10 to 24 with a global lock.
// Assumes a classic Wishbone master on clk_i and peripherals on the same clock.
//
// How it works
// (RQ1) Each pin has a five-bit code choosing which peripheral output drives it.
// (RQ2) Bits above the code in each selector ignore writes and read zero.
// (RQ3) Selectors always read back; writes land only while the lock bit is clear.
// (RQ4) Reset clears every selector code to zero.
// (RQ5) Selectors for pins 19 to 24 exist only on the larger package.
// (RQ6) A code naming no defined function leaves the pin under port control.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module rosel_top
  import rosel_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1,
  parameter logic [NUM_CODE-1:0] FUNC_DEFINED = 32'hffff_fffe
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [BE_W-1:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Function sources
  input wire logic [NUM_CODE-1:0] periph_out_i,
  input wire logic [NUM_SEL-1:0] gpio_out_i,
  // Pins
  output logic [NUM_SEL-1:0] pin_out_o,
  output logic [NUM_SEL-1:0] pin_remap_o,
  output logic remap_lock_o
);

  localparam int unsigned NUM_PRESENT = LARGE_PKG ? NUM_SEL : NUM_SEL_SMALL;

  // Bus state
  logic ack_q;
  logic ack_d;
  logic [DATA_W-1:0] dat_q;
  logic [DATA_W-1:0] dat_d;

  // Selector and lock state
  logic [NUM_SEL-1:0][SEL_W-1:0] sel_q;
  logic [NUM_SEL-1:0][SEL_W-1:0] sel_d;
  logic lock_q;
  logic lock_d;

  // Pin state
  logic [NUM_SEL-1:0] pin_q;
  logic [NUM_SEL-1:0] pin_d;
  logic [NUM_SEL-1:0] remap_q;
  logic [NUM_SEL-1:0] remap_d;

  // Decode
  logic req;
  logic wr_en;
  logic sel_hit;
  logic lock_hit;
  logic [SELIDX_W-1:0] sel_idx;
  logic [NUM_SEL-1:0] mux_pin;
  logic [NUM_SEL-1:0] mux_remap;

  rosel_addr_decode u_decode (
    .adr_i(wb_adr_i),
    .large_pkg_i(LARGE_PKG),
    .sel_hit_o(sel_hit),
    .sel_idx_o(sel_idx),
    .lock_hit_o(lock_hit)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SEL; gi++) begin : g_pin
      rosel_pin_mux u_mux (
        .code_i(sel_q[gi]),
        .defined_i(FUNC_DEFINED),
        .periph_i(periph_out_i),
        .gpio_i(gpio_out_i[gi]),
        .pin_o(mux_pin[gi]),
        .remap_o(mux_remap[gi])
      );
    end
  endgenerate

  // Bus handshake: ack one cycle after the request, write at the ack edge
  always_comb begin
    req = wb_cyc_i && wb_stb_i;
    wr_en = req && ack_q && wb_we_i && wb_sel_i[LANE0];
    ack_d = req && !ack_q;
    dat_d = dat_q;
    if (ack_d) begin
      dat_d = DATA_ZERO;
      if (sel_hit) begin
        dat_d = DATA_W'(sel_q[sel_idx]); // RQ2
      end else if (lock_hit) begin
        dat_d[LOCK_BIT] = lock_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= DATA_ZERO;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // Selector and lock updates
  always_comb begin
    sel_d = sel_q;
    lock_d = lock_q;
    if (wr_en && sel_hit && !lock_q) begin // RQ3
      sel_d[sel_idx] = wb_dat_i[SEL_W-1:0]; // RQ1
    end
    if (wr_en && lock_hit) begin
      lock_d = wb_dat_i[LOCK_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_SEL; i++) begin
        sel_q[i] <= SEL_RST; // RQ4
      end
      lock_q <= LOCK_RST;
    end else begin
      sel_q <= sel_d;
      lock_q <= lock_d;
    end
  end

  // Pin drive; absent pins stay on port control
  always_comb begin
    for (int i = 0; i < NUM_SEL; i++) begin
      if (i < NUM_PRESENT) begin
        pin_d[i] = mux_pin[i];
        remap_d[i] = mux_remap[i]; // RQ6
      end else begin
        pin_d[i] = gpio_out_i[i]; // RQ5
        remap_d[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= '0;
      remap_q <= '0;
    end else begin
      pin_q <= pin_d;
      remap_q <= remap_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign pin_out_o = pin_q;
  assign pin_remap_o = remap_q;
  assign remap_lock_o = lock_q;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_ACK_AFTER_REQ: assert property ( // RQ3
    (req && !ack_q) |=> wb_ack_o
  ) else $error("ack missing one cycle after request");

  AST_ACK_SINGLE: assert property ( // RQ3
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held longer than one cycle");

  AST_UPPER_BITS_ZERO: assert property ( // RQ2
    (wb_ack_o && !wb_we_i && $past(sel_hit)) |-> (wb_dat_o[DATA_W-1:SEL_W] == '0)
  ) else $error("unimplemented selector bits read nonzero");

  AST_WRITE_UNLOCKED: assert property ( // RQ1
    (wr_en && sel_hit && !lock_q) |=> (sel_q[$past(sel_idx)] == $past(wb_dat_i[SEL_W-1:0]))
  ) else $error("unlocked selector write not stored");

  AST_WRITE_LOCKED: assert property ( // RQ3
    (lock_q && !(wr_en && lock_hit)) |=> $stable(sel_q)
  ) else $error("selector changed while locked");

  AST_READBACK: assert property ( // RQ3
    (req && !ack_q && !wb_we_i && sel_hit) ##1 $stable(sel_q)
      |-> (wb_dat_o[SEL_W-1:0] == sel_q[$past(sel_idx)])
  ) else $error("selector read returns wrong code");

  AST_RESET_CLEAR: assert property ( // RQ4
    disable iff (1'b0) $past(rst_i) |-> (sel_q == '0 && !remap_lock_o && !wb_ack_o)
  ) else $error("selectors not cleared by reset");

  AST_SMALL_ABSENT: assert property ( // RQ5
    !LARGE_PKG |-> (pin_remap_o[NUM_SEL-1:NUM_SEL_SMALL] == '0
      && sel_q[NUM_SEL-1:NUM_SEL_SMALL] == '0)
  ) else $error("absent selector active on small package");

  AST_GPIO_FALLBACK: assert property ( // RQ6
    (!FUNC_DEFINED[sel_q[0]]) |=> (!pin_remap_o[0] && pin_out_o[0] == $past(gpio_out_i[0]))
  ) else $error("undefined code did not leave pin on port control");

  AST_FUNC_DRIVE: assert property ( // RQ1
    (FUNC_DEFINED[sel_q[1]] && (NUM_PRESENT > 1))
      |=> (pin_remap_o[1] && pin_out_o[1] == $past(periph_out_i[sel_q[1]]))
  ) else $error("selected function not driven to pin");

  AST_LOCK_WRITE: assert property ( // RQ3
    (wr_en && lock_hit) |=> (remap_lock_o == $past(wb_dat_i[LOCK_BIT]))
  ) else $error("lock bit write not stored");

  COV_WRITE_UNLOCKED: cover property (wr_en && sel_hit && !lock_q);
  COV_WRITE_LOCKED: cover property (wr_en && sel_hit && lock_q);
  COV_READ_SEL: cover property (wb_ack_o && !wb_we_i && $past(sel_hit));
  COV_REMAP_ACTIVE: cover property (pin_remap_o[0]);

endmodule // rosel_top

//--- testbench/rosel_periph_model.sv
// Partner model: peripheral output functions and port output values.
// Assumes one clock; values move every cycle so a stale select shows.
`timescale 1ns/1ps
module rosel_periph_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Sources
  output logic [31:0] periph_o,
  output logic [14:0] gpio_o
);
  logic [15:0] lfsr_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lfsr_q <= 16'h0001;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end
  assign periph_o = {lfsr_q, ~lfsr_q};
  assign gpio_o = lfsr_q[15:1] ^ 15'h2aaa;
endmodule // rosel_periph_model

//--- testbench/rosel_top_tb.sv
// Self-checking bench: both package options share one Wishbone master.
// Assumes the partner model supplies the function sources.
`timescale 1ns/1ps
module rosel_top_tb;
  import rosel_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [BE_W-1:0] wb_sel_i = 4'hf;
  logic [DATA_W-1:0] wb_dat_i = '0;
  logic [DATA_W-1:0] rd, rd_s;
  logic ack, ack_s, lock, lock_s;
  logic [NUM_SEL-1:0] pin, pin_s, rmp, rmp_s, gpio_out_i;
  logic [NUM_CODE-1:0] periph_out_i;
  int failures = 0;
  int checks_done = 0;
  always #2 clk_i = ~clk_i;

  rosel_periph_model PM (.clk_i, .rst_i, .periph_o(periph_out_i), .gpio_o(gpio_out_i));
  rosel_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o(rd), .wb_ack_o(ack), .periph_out_i, .gpio_out_i,
    .pin_out_o(pin), .pin_remap_o(rmp), .remap_lock_o(lock));
  rosel_top #(.LARGE_PKG(1'b0)) DUT_SMALL (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o(rd_s), .wb_ack_o(ack_s), .periph_out_i,
    .gpio_out_i, .pin_out_o(pin_s), .pin_remap_o(rmp_s), .remap_lock_o(lock_s));

  task automatic report_and_stop();
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // Entered just after a rising edge; returns just after one
  task automatic xfer(input logic w, input logic [ADR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q, output logic [DATA_W-1:0] qs);
    int n;
    logic got;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Ack and data seen as sampled at the rising edge
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    got = ack;
    q = rd;
    qs = rd_s;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (got !== 1'b1) begin
      failures++;
      $display("BAD ack exp 1 got 0");
      report_and_stop();
    end
  endtask

  task automatic chk_pins(input logic [4:0] c);
    logic [31:0] p;
    logic [14:0] g;
    @(negedge clk_i);
    p = periph_out_i;
    g = gpio_out_i;
    @(negedge clk_i);
    for (int i = 0; i < 15; i++) begin
      chk("pin", {31'h0, (c != 5'h00) ? p[c] : g[i]}, {31'h0, pin[i]});
      chk("pin_small", {31'h0, (c != 5'h00 && i < 9) ? p[c] : g[i]}, {31'h0, pin_s[i]});
      chk("remap", {31'h0, c != 5'h00}, {31'h0, rmp[i]});
      chk("remap_small", {31'h0, c != 5'h00 && i < 9}, {31'h0, rmp_s[i]});
    end
    @(posedge clk_i);
  endtask

  task automatic t_reset();
    logic [31:0] q, qs;
    for (int i = 0; i < 16; i++) begin
      xfer(1'b0, (i < 15) ? 14'h3b28 + 14'(4 * i) : 14'h3b80, '0, q, qs);
      chk("reset_val", 32'h0, q);
    end
    xfer(1'b1, 14'h0010, 32'hffff_ffff, q, qs);
    xfer(1'b0, 14'h0010, '0, q, qs);
    chk("unmapped", 32'h0, q);
    chk_pins(5'h00);
  endtask

  task automatic t_codes();
    logic [31:0] q, qs;
    for (int c = 0; c < 32; c++) begin
      for (int i = 0; i < 15; i++) xfer(1'b1, 14'h3b28 + 14'(4 * i), 32'hffff_ffe0 | c, q, qs);
      xfer(1'b0, 14'h3b4c, '0, q, qs);
      chk("sel19", 32'(c), q);
      chk("sel19_small", 32'h0, qs);
      chk_pins(5'(c));
    end
  endtask

  task automatic t_lock();
    logic [31:0] q, qs;
    xfer(1'b1, 14'h3b28, 32'h5, q, qs);
    xfer(1'b1, 14'h3b80, 32'h1, q, qs);
    chk("lock", 32'h1, {31'h0, lock});
    xfer(1'b1, 14'h3b28, 32'h9, q, qs);
    xfer(1'b0, 14'h3b28, '0, q, qs);
    chk("locked_sel", 32'h5, q);
    xfer(1'b1, 14'h3b80, 32'h0, q, qs);
    xfer(1'b1, 14'h3b28, 32'h9, q, qs);
    xfer(1'b0, 14'h3b28, '0, q, qs);
    chk("unlocked_sel", 32'h9, q);
    wb_sel_i <= 4'he;
    xfer(1'b1, 14'h3b28, 32'h3, q, qs);
    wb_sel_i <= 4'hf;
    xfer(1'b0, 14'h3b28, '0, q, qs);
    chk("no_lane0_sel", 32'h9, q);
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_codes();
    t_lock();
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    report_and_stop();
  end
endmodule // rosel_top_tb
